/* File: rtl/dac_update_defs.svh */
`ifndef DAC_UPDATE_DEFS_SVH
`define DAC_UPDATE_DEFS_SVH
`define OFS_CONTROL_0   12'h000
`define OFS_DATA_HIGH_0 12'h004
`define OFS_DATA_LOW_0  12'h008
`define OFS_CONTROL_1   12'h00C
`define OFS_DATA_HIGH_1 12'h010
`define OFS_DATA_LOW_1  12'h014
`define CONTROL_RESET   8'h73
`define CONTROL_WMASK   8'hF7
`define BIT_ENABLE      7
`define BIT_SRC_HI      6
`define BIT_SRC_LO      4
`define BIT_RJUST       2
`define BIT_FS_HI       1
`define SRC_HIGH_WRITE  3'h7
`define SRC_RISE        3'h4
`define SRC_FALL        3'h5
`define SRC_ANY         3'h6
`endif

/* File: rtl/dac_update_pkg.sv */
package dac_update_pkg;
   typedef struct packed {
      logic [11:0] word;
      logic [1:0]  full_scale;
      logic        enable;
   } dac_out_t;
   typedef struct packed {
      logic [3:0] low_ovf;
      logic [3:0] high_ovf;
      logic [3:0] mode16;
   } timer_ev_t;
endpackage

/* File: rtl/current_dac_update_control.sv */
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dac_update_defs.svh"
module current_dac_update_control
(
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clk_en,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire dac_update_pkg::timer_ev_t timer_ev,
   input  wire logic                  conversion_strobe_pin,
   output dac_update_pkg::dac_out_t   dac_out_0,
   output dac_update_pkg::dac_out_t   dac_out_1,
   output logic                       bias_enable
);
   logic [7:0] control_reg [2];
   logic [7:0] high_reg [2];
   logic [7:0] low_reg [2];
   dac_update_pkg::dac_out_t out_reg [2];
   logic       strobe_s1_reg;
   logic       strobe_s2_reg;
   logic       strobe_s3_reg;
   logic       bias_reg;
   logic [31:0] prdata_reg;
   logic       pslverr_reg;
   logic       pready_reg;

   wire setup    = psel & ~penable;
   wire wr_setup = setup & pwrite;
   wire [3:0] timer_tick;
   wire rise = strobe_s2_reg & ~strobe_s3_reg;
   wire fall = ~strobe_s2_reg & strobe_s3_reg;
   wire [2:0] ch_sel  = 3'(paddr[11:2] / 10'd3);
   wire [1:0] reg_sel = 2'(paddr[11:2] % 10'd3);
   wire addr_ok = (paddr[11:2] < 10'd6) & (paddr[1:0] == 2'b00);
   wire [7:0] rd_byte = (reg_sel == 2'd0) ? control_reg[ch_sel[0]] & `CONTROL_WMASK
                      : (reg_sel == 2'd1) ? high_reg[ch_sel[0]] : low_reg[ch_sel[0]];

   // timers 2/3 pick overflow byte by mode
   genvar t;
   generate
      for (t = 0; t < 4; t++)
      begin : g_tick
         if (t < 2)
         begin : g_plain
            assign timer_tick[t] = timer_ev.high_ovf[t];
         end
         else
         begin : g_split
            assign timer_tick[t] = timer_ev.mode16[t] ? timer_ev.high_ovf[t]
                                                      : timer_ev.low_ovf[t];
         end
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         strobe_s1_reg <= 1'b0;
         strobe_s2_reg <= 1'b0;
         strobe_s3_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         strobe_s1_reg <= conversion_strobe_pin;
         strobe_s2_reg <= strobe_s1_reg;
         strobe_s3_reg <= strobe_s2_reg;
      end
   end

   // apb answers in setup cycle's following access cycle, zero wait
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
         pready_reg  <= 1'b0;
      end
      else if (clk_en)
      begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~addr_ok;
         prdata_reg  <= (setup & ~pwrite & addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_ch
         wire hit      = wr_setup & addr_ok & (ch_sel == 3'(c));
         wire wr_ctl   = hit & (reg_sel == 2'd0);
         wire wr_high  = hit & (reg_sel == 2'd1);
         wire wr_low   = hit & (reg_sel == 2'd2);
         wire [2:0] src = control_reg[c][`BIT_SRC_HI:`BIT_SRC_LO];
         wire [7:0] new_high = wr_high ? pwdata[7:0] : high_reg[c];
         wire [7:0] new_low  = wr_low ? pwdata[7:0] : low_reg[c];
         wire ev_timer = ~src[2] & timer_tick[src[1:0]];
         wire ev_strobe = ((src == `SRC_RISE) & rise) | ((src == `SRC_FALL) & fall)
                        | ((src == `SRC_ANY) & (rise | fall));
         // only a high write triggers in on-demand mode
         wire ev_write = (src == `SRC_HIGH_WRITE) & wr_high;
         wire update = ev_timer | ev_strobe | ev_write;
         wire [11:0] word = control_reg[c][`BIT_RJUST] ? {new_high[3:0], new_low}
                                                       : {new_high, new_low[7:4]};
         always_ff @(posedge core_clk)
         begin
            if (!rst_n)
            begin
               control_reg[c] <= `CONTROL_RESET;
               high_reg[c]    <= 8'h00;
               low_reg[c]     <= 8'h00;
               out_reg[c]     <= '{word: 12'h000, full_scale: 2'b11, enable: 1'b0};
            end
            else if (clk_en)
            begin
               if (wr_ctl)
                  control_reg[c] <= pwdata[7:0] & `CONTROL_WMASK;
               high_reg[c] <= new_high;
               low_reg[c]  <= new_low;
               if (update)
                  out_reg[c].word <= word;
               out_reg[c].full_scale <= control_reg[c][`BIT_FS_HI:0];
               out_reg[c].enable     <= control_reg[c][`BIT_ENABLE];
            end
         end
      end
   endgenerate

   // shared bias when any channel on
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         bias_reg <= 1'b0;
      else if (clk_en)
         bias_reg <= control_reg[0][`BIT_ENABLE] | control_reg[1][`BIT_ENABLE];
   end

   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign dac_out_0   = out_reg[0];
   assign dac_out_1   = out_reg[1];
   assign bias_enable = bias_reg;

   a_high_write_update: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && g_ch[0].wr_high && control_reg[0][6:4] == 3'h7 && !control_reg[0][2]
      |=> dac_out_0.word == {$past(pwdata[7:0]), low_reg[0][7:4]})
      else $error("high write did not update channel 0");
   a_low_held: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && g_ch[0].wr_low && control_reg[0][6:4] == 3'h7 && !g_ch[0].ev_timer
      |=> $stable(dac_out_0.word))
      else $error("low write changed output");
   a_timer_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && control_reg[1][6:4] == 3'h0 && !timer_ev.high_ovf[0]
      |=> $stable(dac_out_1.word))
      else $error("timer mode updated without overflow");
   a_strobe_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && control_reg[0][6:4] == 3'h5 && rise |=> $stable(dac_out_0.word))
      else $error("falling mode updated on rise");
   a_strobe_one_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && rise |=> !rise)
      else $error("edge produced two pulses");
   a_bias_any: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && (control_reg[0][7] || control_reg[1][7]) |=> bias_enable)
      else $error("bias off while channel enabled");
   a_enable_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en |=> dac_out_1.enable == $past(control_reg[1][7]))
      else $error("enable did not follow control");
   a_range_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en ##1 clk_en |=> dac_out_0.full_scale == $past(control_reg[0][1:0], 1))
      else $error("range did not follow control");
   a_reset_range: assert property (@(posedge core_clk)
      !rst_n |=> dac_out_0.full_scale == 2'b11 && dac_out_1.full_scale == 2'b11)
      else $error("range not 2 mA after reset");

   // named steps shared by the checks below
   sequence s_apb_setup;
      clk_en && setup;
   endsequence
   sequence s_ondemand_high_0;
      clk_en && g_ch[0].wr_high && control_reg[0][6:4] == 3'h7;
   endsequence
   sequence s_ondemand_high_1;
      clk_en && g_ch[1].wr_high && control_reg[1][6:4] == 3'h7;
   endsequence
   sequence s_ondemand_low_1;
      clk_en && g_ch[1].wr_low && control_reg[1][6:4] == 3'h7;
   endsequence
   sequence s_edge_quiet_bus;
      clk_en && !psel && (rise || fall);
   endsequence

   // bus answer checks
   a_apb_ready_next: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_apb_setup
      |=> pready)
      else $error("no ready after setup");
   a_apb_bad_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_apb_setup ##0 !addr_ok
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_apb_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !setup
      |=> !pready && !pslverr && prdata == 32'h0000_0000)
      else $error("bus answer without setup");
   a_freeze_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(pready) && $stable(prdata))
      else $error("bus answer moved while frozen");

   // update source checks
   a_high_write_ch1: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_ondemand_high_1 ##0 !control_reg[1][2]
      |=> dac_out_1.word == {$past(pwdata[7:0]), $past(low_reg[1][7:4])})
      else $error("high write did not update channel 1");
   a_low_held_ch1: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_ondemand_low_1
      |=> $stable(dac_out_1.word))
      else $error("low write changed channel 1");
   a_ondemand_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && control_reg[0][6:4] == 3'h7 && !g_ch[0].wr_high
      |=> $stable(dac_out_0.word))
      else $error("on-demand output moved without high write");
   a_right_ch1: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_ondemand_high_1 ##0 control_reg[1][2]
      |=> dac_out_1.word == {$past(pwdata[3:0]), $past(low_reg[1])})
      else $error("right justified word wrong on channel 1");
   a_right_ch0: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_ondemand_high_0 ##0 control_reg[0][2]
      |=> dac_out_0.word == {$past(pwdata[3:0]), $past(low_reg[0])})
      else $error("right justified word wrong on channel 0");
   a_timer0_update: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !psel && control_reg[0][6:4] == 3'h0 && !control_reg[0][2] && timer_ev.high_ovf[0]
      |=> dac_out_0.word == {$past(high_reg[0]), $past(low_reg[0][7:4])})
      else $error("timer overflow did not update");
   a_timer2_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && control_reg[0][6:4] == 3'h2 && !timer_ev.mode16[2] && !timer_ev.low_ovf[2]
      |=> $stable(dac_out_0.word))
      else $error("timer 2 short mode used wrong byte");
   a_timer3_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && control_reg[0][6:4] == 3'h3 && timer_ev.mode16[3] && !timer_ev.high_ovf[3]
      |=> $stable(dac_out_0.word))
      else $error("timer 3 long mode used wrong byte");
   a_strobe_any_update: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_edge_quiet_bus ##0 (control_reg[0][6:4] == 3'h6 && !control_reg[0][2])
      |=> dac_out_0.word == {$past(high_reg[0]), $past(low_reg[0][7:4])})
      else $error("strobe edge did not update");
   a_strobe_rise_update: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !psel && control_reg[0][6:4] == 3'h4 && !control_reg[0][2] && rise
      |=> dac_out_0.word == {$past(high_reg[0]), $past(low_reg[0][7:4])})
      else $error("rising strobe did not update");
   a_strobe_fall_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && control_reg[0][6:4] == 3'h4 && fall
      |=> $stable(dac_out_0.word))
      else $error("rising mode updated on fall");
   a_sync_two_stage: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en ##1 (clk_en && rise)
      |-> $past(strobe_s1_reg))
      else $error("edge seen without first sync stage");
   a_freeze_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(dac_out_0.word) && $stable(dac_out_1.word))
      else $error("output word moved while frozen");

   // range, enable and reset checks
   a_bias_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !control_reg[0][7] && !control_reg[1][7]
      |=> !bias_enable)
      else $error("bias on with both channels off");
   a_enable_ch0: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en
      |=> dac_out_0.enable == $past(control_reg[0][7]))
      else $error("channel 0 enable did not follow control");
   a_range_ch1: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en
      |=> dac_out_1.full_scale == $past(control_reg[1][1:0]))
      else $error("channel 1 range did not follow control");
   a_reset_word: assert property (@(posedge core_clk)
      !rst_n
      |=> dac_out_0.word == 12'h000 && dac_out_1.word == 12'h000 && !bias_enable)
      else $error("outputs not cleared by reset");
endmodule

/* File: verification/current_dac_update_control_tb.sv */
`timescale 1ns/1ps
`include "dac_update_defs.svh"
module current_dac_update_control_tb;
   logic                      core_clk;
   logic                      rst_n;
   logic                      clk_en;
   logic                      psel;
   logic                      penable;
   logic                      pwrite;
   logic [11:0]               paddr;
   logic [31:0]               pwdata;
   logic [31:0]               prdata;
   logic                      pready;
   logic                      pslverr;
   logic                      strobe;
   logic                      bias_enable;
   logic [31:0]               rd;
   logic                      err;
   logic [11:0]               w;
   logic [7:0]                k;
   dac_update_pkg::timer_ev_t timer_ev;
   dac_update_pkg::dac_out_t  dac_out_0;
   dac_update_pkg::dac_out_t  dac_out_1;
   int                        bad_count;
   int                        comparisons;

   current_dac_update_control i_dut
   (
      .core_clk              (core_clk),
      .rst_n                 (rst_n),
      .clk_en                (clk_en),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .timer_ev              (timer_ev),
      .conversion_strobe_pin (strobe),
      .dac_out_0             (dac_out_0),
      .dac_out_1             (dac_out_1),
      .bias_enable           (bias_enable)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cw(input logic [11:0] exp);
      check({20'h0_0000, dac_out_0.word}, {20'h0_0000, exp});
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         bad_count++;
         $display("MISMATCH at %0t: no bus answer", $time);
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 8'h00);
      check(rd, exp);
      check({31'h0, err}, {31'h0, e});
   endtask

   task automatic pulse(input logic [3:0] lo, input logic [3:0] hi);
      timer_ev.low_ovf  <= lo;
      timer_ev.high_ovf <= hi;
      @(posedge core_clk);
      timer_ev.low_ovf  <= 4'h0;
      timer_ev.high_ovf <= 4'h0;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic edge_step(input logic v, input logic upd);
      k = k + 8'h01;
      apb(1'b1, `OFS_DATA_HIGH_0, k);
      cw(w);
      strobe <= v;
      repeat (6) @(posedge core_clk);
      if (upd)
         w = {k, 4'h3};
      cw(w);
   endtask

   task automatic t_regs;
      rchk(`OFS_CONTROL_1, 32'h0000_0073, 1'b0);
      check({dac_out_1, bias_enable}, {12'h000, 2'b11, 2'b00});
      apb(1'b1, `OFS_CONTROL_0, 8'hFF);
      rchk(`OFS_CONTROL_0, 32'h0000_00F7, 1'b0);
      rchk(12'h018, 32'h0000_0000, 1'b1);
   endtask

   task automatic t_ondemand;
      apb(1'b1, `OFS_CONTROL_0, 8'h73);
      apb(1'b1, `OFS_DATA_LOW_0, 8'hA5);
      cw(12'h000);
      apb(1'b1, `OFS_DATA_HIGH_0, 8'h5C);
      cw(12'h5CA);
      apb(1'b1, `OFS_CONTROL_0, 8'h77);
      apb(1'b1, `OFS_DATA_LOW_0, 8'h34);
      apb(1'b1, `OFS_DATA_HIGH_0, 8'hF2);
      cw(12'h234);
   endtask

   task automatic t_range;
      for (int f = 0; f < 4; f++)
      begin
         apb(1'b1, `OFS_CONTROL_1, 8'hF0 | 8'(f));
         repeat (2) @(posedge core_clk);
         check({dac_out_1.full_scale, dac_out_1.enable, dac_out_0.enable, bias_enable},
               {f[1:0], 3'b101});
      end
      apb(1'b1, `OFS_CONTROL_1, 8'h73);
      repeat (2) @(posedge core_clk);
      check({dac_out_1.enable, bias_enable}, 2'b00);
   endtask

   task automatic t_timer;
      logic [3:0] m;
      w = 12'h234;
      for (int t = 0; t < 4; t++)
      begin
         m = 4'h1 << t;
         timer_ev.mode16 <= {t == 3, 3'b000};
         apb(1'b1, `OFS_CONTROL_0, 8'h03 | 8'(t << 4));
         apb(1'b1, `OFS_DATA_HIGH_0, 8'h10 + 8'(t));
         cw(w);
         pulse(t == 2 ? 4'h0 : m, t == 2 ? m : 4'h0);
         cw(w);
         pulse(t == 2 ? m : 4'h0, t == 2 ? 4'h0 : m);
         w = {8'h10 + 8'(t), 4'h3};
         cw(w);
      end
   endtask

   task automatic t_strobe;
      k = 8'h40;
      for (int c = 4; c < 7; c++)
      begin
         apb(1'b1, `OFS_CONTROL_0, 8'h03 | 8'(c << 4));
         edge_step(1'b1, c != 5);
         edge_step(1'b0, c != 4);
      end
   endtask

   task automatic t_freeze;
      apb(1'b1, `OFS_CONTROL_0, 8'h33);
      apb(1'b1, `OFS_DATA_HIGH_0, 8'h77);
      clk_en <= 1'b0;
      pulse(4'h0, 4'h8);
      cw(w);
      clk_en <= 1'b1;
      pulse(4'h0, 4'h8);
      w = 12'h773;
      cw(w);
   endtask

   task automatic t_eight_bit;
      apb(1'b1, `OFS_CONTROL_0, 8'h73);
      apb(1'b1, `OFS_DATA_LOW_0, 8'h00);
      apb(1'b1, `OFS_DATA_HIGH_0, 8'h9A);
      cw(12'h9A0);
      apb(1'b1, `OFS_DATA_HIGH_0, 8'h3B);
      cw(12'h3B0);
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      rst_n    = 1'b0;
      clk_en   = 1'b1;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0000_0000;
      strobe   = 1'b0;
      timer_ev = '0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs;
      t_ondemand;
      t_range;
      t_timer;
      t_strobe;
      t_freeze;
      t_eight_bit;
      conclude;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      conclude;
   end
endmodule
